//--- include/ddrp_pkg.sv
// shared constants and types for the ddr2 command, address and data pin block
package ddrp_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // pin widths of the x16 organisation
  localparam int DQ_W   = 16;
  localparam int LANES  = 2;
  localparam int LANE_W = 8;
  localparam int BA_W   = 3;
  localparam int ADDR_W = 14;
  localparam int NBANK  = 8;

  ////////////////////////////////////////////////////////////////////////////////
  // burst and storage shape
  localparam int BURST_LEN = 4;
  localparam int BEAT_W    = 2;
  localparam int MEM_AW    = BA_W + BEAT_W;
  localparam int MEM_D     = NBANK * BURST_LEN;
  localparam int CL_DEF    = 4;
  localparam int CNT_W     = 4;

  localparam logic [BEAT_W-1:0] BEAT_ONE  = 2'h1;
  localparam logic [BEAT_W-1:0] BEAT_LAST = 2'h3;
  localparam logic [CNT_W-1:0]  CNT_ONE   = 4'h1;

  ////////////////////////////////////////////////////////////////////////////////
  // command codes on {cs_n, ras_n, cas_n, we_n}; chip select high never matches
  localparam logic [3:0] CMD_MRS = 4'h0;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_WR  = 4'h4;
  localparam logic [3:0] CMD_RD  = 4'h5;
  localparam logic [3:0] CMD_NOP = 4'h7;

  ////////////////////////////////////////////////////////////////////////////////
  // address bit roles and mode register selection
  localparam int AP_BIT           = 10;
  localparam int EMR_DQSN_OFF_BIT = 10;
  localparam int EMR_RTT_A_BIT    = 2;
  localparam int EMR_RTT_B_BIT    = 6;

  localparam logic [BA_W-1:0]   SEL_MR   = 3'h0;
  localparam logic [BA_W-1:0]   SEL_EMR1 = 3'h1;
  localparam logic [BA_W-1:0]   SEL_EMR2 = 3'h2;
  localparam logic [BA_W-1:0]   SEL_EMR3 = 3'h3;
  localparam logic [ADDR_W-1:0] MODE_RST = 14'h0000;

  typedef enum logic [1:0] {PH_IDLE, PH_WAIT, PH_BURST} ddrp_phase_type;

endpackage

//--- rtl/ddrp_sync.sv
// three-stage level synchroniser into the core clock domain
`timescale 1ns/1ps
module ddrp_sync #(
  parameter int W = 1
) (
  // destination clock and reset
  input  wire logic         clk,
  input  wire logic         reset,
  // level from the link domain
  input  wire logic [W-1:0] async_in,
  // settled level
  output logic      [W-1:0] sync_out
);
  import ddrp_pkg::*;

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } ddrp_sync_type;

  ddrp_sync_type st_r;
  ddrp_sync_type st_nxt;

  // a bit only moves once stages two and three agree; s1 feeds s2 alone
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = async_in;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (int i = 0; i < W; i++) begin
      if (st_r.s2[i] == st_r.s3[i]) begin
        st_nxt.q[i] = st_r.s3[i];
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sync_out = st_r.q;

endmodule

//--- rtl/ddrp_pulse.sv
// toggle crossing that carries one-cycle events from the link to the core
`timescale 1ns/1ps
module ddrp_pulse (
  // clocks and reset
  input  wire logic src_clk,
  input  wire logic dst_clk,
  input  wire logic reset,
  // event in the link domain
  input  wire logic src_pulse,
  // event in the core domain
  output logic      dst_pulse
);
  import ddrp_pkg::*;

  typedef struct packed {
    logic tog;
  } ddrp_psrc_type;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic seen;
    logic pulse;
  } ddrp_pdst_type;

  ddrp_psrc_type src_r;
  ddrp_psrc_type src_nxt;
  ddrp_pdst_type dst_r;
  ddrp_pdst_type dst_nxt;

  ////////////////////////////////////////////////////////////////////////////////
  // source side: each event flips the toggle; a level held for fewer than two dst_clk cycles can be missed, so back-to-back events can be lost
  always_comb begin
    src_nxt     = src_r;
    src_nxt.tog = src_r.tog ^ src_pulse;
  end

  always_ff @(posedge src_clk or posedge reset) begin
    if (reset) begin
      src_r <= '0;
    end else begin
      src_r <= src_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // destination side: count a flip once stages two and three agree
  always_comb begin
    dst_nxt       = dst_r;
    dst_nxt.s1    = src_r.tog;
    dst_nxt.s2    = dst_r.s1;
    dst_nxt.s3    = dst_r.s2;
    dst_nxt.pulse = 1'b0;
    if ((dst_r.s2 == dst_r.s3) && (dst_r.s3 != dst_r.seen)) begin
      dst_nxt.pulse = 1'b1;
      dst_nxt.seen  = dst_r.s3;
    end
  end

  always_ff @(posedge dst_clk or posedge reset) begin
    if (reset) begin
      dst_r <= '0;
    end else begin
      dst_r <= dst_nxt;
    end
  end

  assign dst_pulse = dst_r.pulse;

endmodule

//--- rtl/ddrp_pins.sv
// ddr2 x16 command decode, bank state, mode registers, data pins and termination
// Overview of operation
// - chip select high masks the command
// - registered odt high enables termination
// - termination covers every dq, strobe, mask pin
// - odt ignored when extended register disables it
// - command decoded from cs, ras, cas, we
// - masked write beats are discarded
// - one mask value sampled per beat
// - bank address picks the bank acted on
// - bank address picks mode register written
// - row with activate, column with read/write
// - address bit ten selects all-bank precharge
// - single precharge closes only addressed bank
// - address carries opcode during mode set
// - device drives strobe with read data
// - read strobe edges align with data
// - lower strobe times low byte, upper high
// - extended bit ten picks single or differential
// - inputs sampled on rising link clock
`timescale 1ns/1ps
module ddrp_pins #(
  parameter int CL = ddrp_pkg::CL_DEF
) (
  // core clock and reset
  input  wire logic                                    clk,
  input  wire logic                                    reset,
  // link clock and command pins
  input  wire logic                                    ck,
  input  wire logic                                    cke,
  input  wire logic                                    cs_n,
  input  wire logic                                    ras_n,
  input  wire logic                                    cas_n,
  input  wire logic                                    we_n,
  input  wire logic [ddrp_pkg::BA_W-1:0]               ba,
  input  wire logic [ddrp_pkg::ADDR_W-1:0]             addr,
  input  wire logic                                    odt,
  // data and mask pins
  input  wire logic [ddrp_pkg::DQ_W-1:0]               dq_i,
  output logic      [ddrp_pkg::DQ_W-1:0]               dq_o,
  output logic      [ddrp_pkg::DQ_W-1:0]               dq_oe,
  input  wire logic [ddrp_pkg::LANES-1:0]              dm_i,
  // strobe pins, lane 0 low byte, lane 1 high byte
  input  wire logic [ddrp_pkg::LANES-1:0]              dqs_i,
  output logic      [ddrp_pkg::LANES-1:0]              dqs_o,
  output logic      [ddrp_pkg::LANES-1:0]              dqs_oe,
  input  wire logic [ddrp_pkg::LANES-1:0]              dqs_n_i,
  output logic      [ddrp_pkg::LANES-1:0]              dqs_n_o,
  output logic      [ddrp_pkg::LANES-1:0]              dqs_n_oe,
  // on-die termination enables
  output logic      [ddrp_pkg::DQ_W-1:0]               term_dq_en,
  output logic      [ddrp_pkg::LANES-1:0]              term_dqs_en,
  output logic      [ddrp_pkg::LANES-1:0]              term_dqs_n_en,
  output logic      [ddrp_pkg::LANES-1:0]              term_dm_en,
  // core side status
  output logic                                         core_term_on,
  output logic                                         core_strobe_diff,
  output logic      [ddrp_pkg::NBANK-1:0]              core_bank_open,
  output logic                                         core_write_done,
  output logic                                         core_read_done
);
  import ddrp_pkg::*;

  localparam logic [CNT_W-1:0] RD_CNT = CNT_W'(CL);
  localparam logic [CNT_W-1:0] WR_CNT = CNT_W'(CL - 1);

  ////////////////////////////////////////////////////////////////////////////////
  // link-domain state
  typedef struct packed {
    logic [NBANK-1:0][ADDR_W-1:0] row;
    logic [NBANK-1:0]             open;
    logic [ADDR_W-1:0]            mr;
    logic [ADDR_W-1:0]            emr1;
    logic [ADDR_W-1:0]            emr2;
    logic [ADDR_W-1:0]            emr3;
    logic [MEM_D-1:0][DQ_W-1:0]   mem;
    ddrp_phase_type               rd_ph;
    logic [CNT_W-1:0]             rd_cnt;
    logic [BEAT_W-1:0]            rd_beat;
    logic [BA_W-1:0]              rd_ba;
    logic [BEAT_W-1:0]            rd_col;
    logic                         rd_ap;
    ddrp_phase_type               wr_ph;
    logic [CNT_W-1:0]             wr_cnt;
    logic [BEAT_W-1:0]            wr_beat;
    logic [BA_W-1:0]              wr_ba;
    logic [BEAT_W-1:0]            wr_col;
    logic                         wr_ap;
    logic [LANES-1:0]             dqs_prev;
    logic [DQ_W-1:0]              dq_o;
    logic                         dq_oe;
    logic [LANES-1:0]             dqs_o;
    logic                         dqs_oe;
    logic                         dqs_n_oe;
    logic                         term;
    logic                         rd_done;
    logic                         wr_done;
  } ddrp_link_type;

  ddrp_link_type st_r;
  ddrp_link_type st_nxt;

  logic [3:0]               cmd;
  logic                     rd_go;
  logic                     wr_go;
  logic                     rtt_on;
  logic                     diff_on;
  logic [LANES-1:0]         strobe_ok;
  logic [MEM_AW-1:0]        wr_idx;
  logic [NBANK+1:0]         stat_sync;

  ////////////////////////////////////////////////////////////////////////////////
  // helpers shared by the read and write paths

  // sequential burst order wraps inside the four-beat block
  function automatic logic [MEM_AW-1:0] mem_idx(input logic [BA_W-1:0]   b,
                                                input logic [BEAT_W-1:0] col,
                                                input logic [BEAT_W-1:0] beat);
    logic [BEAT_W-1:0] off;
    off     = col + beat;
    mem_idx = {b, off};
  endfunction

  // auto-precharge at burst end closes the bank the burst used
  function automatic logic [NBANK-1:0] close_bank(input logic [NBANK-1:0] open,
                                                  input logic [BA_W-1:0]  b,
                                                  input logic             ap);
    logic [NBANK-1:0] res;
    res = open;
    if (ap) begin
      res[b] = 1'b0;
    end
    close_bank = res;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // command decode; deselect and low cke fall through as no operation
  always_comb begin
    cmd = {cs_n, ras_n, cas_n, we_n};
    if (!cke) begin
      cmd = CMD_NOP; // command inputs are off while cke is low
    end
  end

  assign rtt_on  = st_r.emr1[EMR_RTT_A_BIT] || st_r.emr1[EMR_RTT_B_BIT];
  assign diff_on = !st_r.emr1[EMR_DQSN_OFF_BIT];

  // a new access needs an open bank and both data paths idle, else it is dropped
  assign rd_go = (cmd == CMD_RD) && st_r.open[ba] && (st_r.rd_ph == PH_IDLE)
                 && (st_r.wr_ph == PH_IDLE);
  assign wr_go = (cmd == CMD_WR) && st_r.open[ba] && (st_r.rd_ph == PH_IDLE)
                 && (st_r.wr_ph == PH_IDLE);

  // a lane beat counts only on a fresh strobe edge, and a valid pair when differential
  always_comb begin
    for (int l = 0; l < LANES; l++) begin
      strobe_ok[l] = (dqs_i[l] != st_r.dqs_prev[l])
                     && (!diff_on || (dqs_n_i[l] != dqs_i[l]));
    end
  end

  assign wr_idx = mem_idx(st_r.wr_ba, st_r.wr_col, st_r.wr_beat);

  ////////////////////////////////////////////////////////////////////////////////
  // next link state, all inputs taken at the rising link clock edge
  always_comb begin
    st_nxt          = st_r;
    st_nxt.rd_done  = 1'b0;
    st_nxt.wr_done  = 1'b0;
    st_nxt.dqs_prev = dqs_i;
    st_nxt.term     = odt && rtt_on;

    // bank and mode register commands
    case (cmd)
      CMD_ACT: begin
        st_nxt.open[ba] = 1'b1;
        st_nxt.row[ba]  = addr;
      end
      CMD_PRE: begin
        if (addr[AP_BIT]) begin
          st_nxt.open = '0;
        end else begin
          st_nxt.open[ba] = 1'b0;
        end
      end
      CMD_MRS: begin
        case (ba)
          SEL_MR:   st_nxt.mr   = addr;
          SEL_EMR1: st_nxt.emr1 = addr;
          SEL_EMR2: st_nxt.emr2 = addr;
          SEL_EMR3: st_nxt.emr3 = addr;
          default:  st_nxt.mr   = st_r.mr;
        endcase
      end
      default: st_nxt.open = st_r.open;
    endcase

    // read path: wait the latency, then four beats
    case (st_r.rd_ph)
      PH_IDLE: begin
        if (rd_go) begin
          st_nxt.rd_ph   = PH_WAIT;
          st_nxt.rd_cnt  = RD_CNT;
          st_nxt.rd_ba   = ba;
          st_nxt.rd_col  = addr[BEAT_W-1:0];
          st_nxt.rd_ap   = addr[AP_BIT];
          st_nxt.rd_beat = '0;
        end
      end
      PH_WAIT: begin
        if (st_r.rd_cnt == CNT_ONE) begin
          st_nxt.rd_ph = PH_BURST;
        end else begin
          st_nxt.rd_cnt = st_r.rd_cnt - CNT_ONE;
        end
      end
      PH_BURST: begin
        st_nxt.rd_beat = st_r.rd_beat + BEAT_ONE;
        if (st_r.rd_beat == BEAT_LAST) begin
          st_nxt.rd_ph   = PH_IDLE;
          st_nxt.rd_done = 1'b1;
          st_nxt.open    = close_bank(st_nxt.open, st_r.rd_ba, st_r.rd_ap);
        end
      end
      default: st_nxt.rd_ph = PH_IDLE;
    endcase

    // write path: wait one cycle less, then sample four beats
    case (st_r.wr_ph)
      PH_IDLE: begin
        if (wr_go) begin
          st_nxt.wr_ph   = PH_WAIT;
          st_nxt.wr_cnt  = WR_CNT;
          st_nxt.wr_ba   = ba;
          st_nxt.wr_col  = addr[BEAT_W-1:0];
          st_nxt.wr_ap   = addr[AP_BIT];
          st_nxt.wr_beat = '0;
        end
      end
      PH_WAIT: begin
        if (st_r.wr_cnt == CNT_ONE) begin
          st_nxt.wr_ph = PH_BURST;
        end else begin
          st_nxt.wr_cnt = st_r.wr_cnt - CNT_ONE;
        end
      end
      PH_BURST: begin
        // each lane takes its byte on a fresh strobe edge unless its mask bit rides with this beat
        for (int l = 0; l < LANES; l++) begin
          if (!dm_i[l] && strobe_ok[l]) begin
            st_nxt.mem[wr_idx][l*LANE_W +: LANE_W] = dq_i[l*LANE_W +: LANE_W];
          end
        end
        st_nxt.wr_beat = st_r.wr_beat + BEAT_ONE;
        if (st_r.wr_beat == BEAT_LAST) begin
          st_nxt.wr_ph   = PH_IDLE;
          st_nxt.wr_done = 1'b1;
          st_nxt.open    = close_bank(st_nxt.open, st_r.wr_ba, st_r.wr_ap);
        end
      end
      default: st_nxt.wr_ph = PH_IDLE;
    endcase

    // pin drivers follow the next read phase so beat zero leaves with the burst
    st_nxt.dq_oe    = (st_nxt.rd_ph == PH_BURST);
    st_nxt.dq_o     = st_r.mem[mem_idx(st_nxt.rd_ba, st_nxt.rd_col, st_nxt.rd_beat)];
    st_nxt.dqs_oe   = st_nxt.dq_oe;
    st_nxt.dqs_o    = {LANES{~st_nxt.rd_beat[0]}}; // one edge per beat
    st_nxt.dqs_n_oe = st_nxt.dq_oe && diff_on;
  end

  // state moves only on the rising link clock
  always_ff @(posedge ck or posedge reset) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pin outputs, all from link-domain flops
  assign dq_o          = st_r.dq_o;
  assign dq_oe         = {DQ_W{st_r.dq_oe}};
  assign dqs_o         = st_r.dqs_o; // one strobe per byte lane
  assign dqs_oe        = {LANES{st_r.dqs_oe}};
  assign dqs_n_o       = ~st_r.dqs_o;
  assign dqs_n_oe      = {LANES{st_r.dqs_n_oe}};
  // termination reaches every data-related pin of both lanes
  assign term_dq_en    = {DQ_W{st_r.term}};
  assign term_dqs_en   = {LANES{st_r.term}};
  assign term_dqs_n_en = {LANES{st_r.term}};
  assign term_dm_en    = {LANES{st_r.term}};

  ////////////////////////////////////////////////////////////////////////////////
  // crossings to the core; bank bits are near static so per-bit sync is enough
  ddrp_sync #(
    .W (NBANK + 2)
  ) u_stat_sync (
    .clk      (clk),
    .reset    (reset),
    .async_in ({st_r.term, diff_on, st_r.open}),
    .sync_out (stat_sync)
  );

  assign core_term_on     = stat_sync[NBANK+1];
  assign core_strobe_diff = stat_sync[NBANK];
  assign core_bank_open   = stat_sync[NBANK-1:0];

  ddrp_pulse u_wr_evt (
    .src_clk   (ck),
    .dst_clk   (clk),
    .reset     (reset),
    .src_pulse (st_r.wr_done),
    .dst_pulse (core_write_done)
  );

  ddrp_pulse u_rd_evt (
    .src_clk   (ck),
    .dst_clk   (clk),
    .reset     (reset),
    .src_pulse (st_r.rd_done),
    .dst_pulse (core_read_done)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // checks on the link domain
  a_cs_masks_cmd: assert property (
    @(posedge ck) disable iff (reset)
    (cs_n && st_r.rd_ph == PH_IDLE && st_r.wr_ph == PH_IDLE) |=> (st_r.rd_ph == PH_IDLE)
  ) else $error("command taken while chip select high");

  a_odt_enable: assert property (
    @(posedge ck) disable iff (reset)
    (odt && rtt_on) |=> (term_dq_en[0] && term_dm_en[1])
  ) else $error("termination not enabled after odt");

  a_odt_ignored: assert property (
    @(posedge ck) disable iff (reset)
    (!rtt_on) |=> (term_dqs_en == '0)
  ) else $error("termination on while disabled in mode register");

  a_odt_all_pins: assert property (
    @(posedge ck) disable iff (reset)
    (term_dq_en == {DQ_W{term_dqs_n_en[0]}}) && (term_dm_en == term_dqs_en)
  ) else $error("termination differs between pins");

  a_prech_all: assert property (
    @(posedge ck) disable iff (reset)
    (cmd == CMD_PRE && addr[AP_BIT]) |=> (st_r.open == '0)
  ) else $error("all-bank precharge left a bank open");

  a_prech_one: assert property (
    @(posedge ck) disable iff (reset)
    (cmd == CMD_PRE && !addr[AP_BIT]) |=> !st_r.open[$past(ba)]
  ) else $error("single precharge missed its bank");

  a_act_opens: assert property (
    @(posedge ck) disable iff (reset)
    (cmd == CMD_ACT) |=> (st_r.open[$past(ba)] && st_r.row[$past(ba)] == $past(addr))
  ) else $error("activate did not open the bank with its row");

  a_emr_select: assert property (
    @(posedge ck) disable iff (reset)
    (cmd == CMD_MRS && ba == SEL_EMR1) |=> (st_r.emr1 == $past(addr) && $stable(st_r.mr))
  ) else $error("extended mode write went to the wrong register");

  a_read_burst: assert property (
    @(posedge ck) disable iff (reset)
    $rose(dq_oe[0]) |-> dq_oe[0] [*4] ##1 !dq_oe[0]
  ) else $error("read burst not four beats");

  a_read_start: assert property (
    @(posedge ck) disable iff (reset)
    rd_go |-> ##[1:8] (dqs_oe == 2'h3 && dq_oe[0])
  ) else $error("read data never driven");

  a_strobe_edge: assert property (
    @(posedge ck) disable iff (reset)
    (dq_oe[0] && $past(dq_oe[0])) |-> (dqs_o != $past(dqs_o))
  ) else $error("read strobe did not toggle with data");

  a_strobe_form: assert property (
    @(posedge ck) disable iff (reset)
    $rose(dq_oe[0]) |-> ((dqs_n_oe == '0) == $past(st_r.emr1[EMR_DQSN_OFF_BIT]))
  ) else $error("complementary strobe form wrong");

  a_mask_drop: assert property (
    @(posedge ck) disable iff (reset)
    (st_r.wr_ph == PH_BURST && dm_i[0])
      |-> (st_nxt.mem[wr_idx][LANE_W-1:0] == st_r.mem[wr_idx][LANE_W-1:0])
  ) else $error("masked byte was written");

endmodule

//--- test/ddrp_ctrl_model.sv
// controller-side model that drives commands, write data and strobes
`timescale 1ns/1ps
module ddrp_ctrl_model #(
  parameter int CL = 4
) (
  // link clock
  input  wire logic  ck,
  // command pins
  output logic       cke,
  output logic       cs_n,
  output logic       ras_n,
  output logic       cas_n,
  output logic       we_n,
  output logic [2:0] ba,
  output logic [13:0] addr,
  output logic       odt,
  // write data pins
  output logic [15:0] dq,
  output logic [1:0] dm,
  output logic [1:0] dqs
);
  ////////////////////////////////////////
  // idle levels; cke never drops so accesses are never cut short
  initial begin
    cke = 1'b1;
    {cs_n, ras_n, cas_n, we_n} = 4'h7;
    ba = 3'h0;
    addr = 14'h0;
    odt = 1'b0;
    dq = 16'h0;
    dm = 2'h0;
    dqs = 2'h3;
  end
  // one command for one ck cycle, then nop with scrambled address lines
  task cmd(input logic [3:0] c, input logic [2:0] b, input logic [13:0] a);
    @(posedge ck);
    #1;
    {cs_n, ras_n, cas_n, we_n} = c;
    ba = b;
    addr = a;
    @(posedge ck);
    #1;
    {cs_n, ras_n, cas_n, we_n} = 4'h7;
    ba = ~b;
    addr = ~a;
  endtask
  // write burst: low preamble, then one strobe toggle and one mask per beat
  task wr(input logic [63:0] d, input logic [7:0] m);
    repeat (CL - 2) @(posedge ck);
    #1;
    dqs = 2'h0;
    for (int i = 0; i < 4; i++) begin
      @(posedge ck);
      #1;
      dq = d[16*i +: 16];
      dm = m[2*i +: 2];
      dqs = {2{~i[0]}};
    end
    @(posedge ck);
    #1;
    // released lines flip so stale data is never mistaken for a beat
    dq = ~dq;
    dm = ~dm;
    dqs = ~dqs;
  endtask
endmodule

//--- test/tb.sv
// self-checking bench for the ddr2 pin block
`timescale 1ns/1ps
module tb;
  import ddrp_pkg::*;
  localparam int CL = 4;
  logic clk = 1'b0;
  logic ck = 1'b0;
  logic reset = 1'b1;
  logic cke, cs_n, ras_n, cas_n, we_n, odt, diff_exp = 1'b1;
  logic [2:0] ba;
  logic [13:0] addr;
  logic [15:0] m_dq, dq_o, dq_oe, dq_w, t_dq, mem [0:31];
  logic [1:0] m_dm, m_dqs, dqs_o, dqs_oe, dqs_n_o, dqs_n_oe, dqs_w, dqs_n_w, t_s, t_n, t_m;
  logic term_on, s_diff, w_done, r_done;
  logic [7:0] b_open;
  logic [15:0] q [$];
  int errors = 0, comparisons = 0, cycles = 0, rb = 0, seed = 93, n_wr = 0, n_rd = 0;
  ////////////////////////////////////////
  // clocks of unrelated phase
  always #4 clk = ~clk;
  initial begin
    #2.3;
    forever #7.5 ck = ~ck;
  end
  // wire levels from the device enables, else the model's drive
  assign dq_w = (dq_oe & dq_o) | (~dq_oe & m_dq);
  assign dqs_w = (dqs_oe & dqs_o) | (~dqs_oe & m_dqs);
  assign dqs_n_w = (dqs_n_oe & dqs_n_o) | (~dqs_n_oe & ~m_dqs);
  ddrp_ctrl_model #(.CL(CL)) ctl (.ck(ck), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .odt(odt), .dq(m_dq), .dm(m_dm),
    .dqs(m_dqs));
  ddrp_pins #(.CL(CL)) dut (.clk(clk), .reset(reset), .ck(ck), .cke(cke), .cs_n(cs_n),
    .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .odt(odt),
    .dq_i(dq_w), .dq_o(dq_o), .dq_oe(dq_oe), .dm_i(m_dm), .dqs_i(dqs_w), .dqs_o(dqs_o),
    .dqs_oe(dqs_oe), .dqs_n_i(dqs_n_w), .dqs_n_o(dqs_n_o), .dqs_n_oe(dqs_n_oe),
    .term_dq_en(t_dq), .term_dqs_en(t_s), .term_dqs_n_en(t_n), .term_dm_en(t_m),
    .core_term_on(term_on), .core_strobe_diff(s_diff), .core_bank_open(b_open),
    .core_write_done(w_done), .core_read_done(r_done));
  task check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task wrap_up;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // read beats stand a whole ck cycle, so they are taken at the falling edge
  always @(negedge ck) begin
    if (dq_oe[0] === 1'b1) begin
      if (q.size() == 0) check(dq_oe, 16'h0);
      else check(dq_o, q.pop_front());
      check(dq_oe, 16'hffff);
      check({14'h0, dqs_oe}, 16'h3);
      check({14'h0, dqs_o}, {14'h0, {2{~rb[0]}}});
      check({14'h0, dqs_n_o}, {14'h0, {2{rb[0]}}});
      check({14'h0, dqs_n_oe}, {14'h0, {2{diff_exp}}});
      rb++;
    end else rb = 0;
  end
  // hang guard, far beyond the few hundred cycles the tests need
  // burst-end events from both crossings are tallied for the closing check
  always @(posedge clk) begin
    cycles++;
    if (w_done === 1'b1) n_wr++;
    if (r_done === 1'b1) n_rd++;
    if (cycles == 20000) begin
      errors++;
      $display("BAD %0t run did not finish", $time);
      wrap_up;
    end
  end
  task settle;
    repeat (8) @(posedge clk);
    #1;
  endtask
  // note the expected words, then issue the read
  task rd(input logic [2:0] b, input logic [1:0] col);
    for (int i = 0; i < 4; i++) q.push_back(mem[{b, 2'(col + i)}]);
    ctl.cmd(CMD_RD, b, {12'h0, col});
    repeat (CL + 6) @(posedge ck);
  endtask
  // random burst at column 0; masked lanes keep their old bytes
  task wrb(input logic [2:0] b, input logic [7:0] m);
    logic [63:0] d;
    d = {$random(seed), $random(seed)};
    for (int i = 0; i < 8; i++) if (!m[i]) mem[{b, 2'(i / 2)}][8*(i%2) +: 8] = d[8*i +: 8];
    ctl.cmd(CMD_WR, b, 14'h0);
    ctl.wr(d, m);
    repeat (CL + 4) @(posedge ck);
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk);
    check({t_dq[13:0], dqs_n_o}, 16'h3);
    #1 reset = 1'b0;
    ctl.cmd(CMD_ACT, 3'h2, 14'h1555);
    ctl.cmd(CMD_ACT, 3'h5, 14'h2aaa);
    settle;
    check({s_diff, 7'h0, b_open}, 16'h8024);
    ctl.cmd(CMD_PRE, 3'h2, 14'h0);
    settle;
    check({8'h0, b_open}, 16'h20);
    ctl.cmd(CMD_PRE, 3'h0, 14'h0400);
    settle;
    check({8'h0, b_open}, 16'h0);
    $display("test banks done");
    ctl.cmd(CMD_ACT, 3'h2, 14'h0);
    wrb(3'h2, 8'h00);
    rd(3'h2, 2'h0);
    wrb(3'h2, 8'h24);
    rd(3'h2, 2'h1);
    ctl.cmd(4'hd, 3'h2, 14'h0);
    repeat (CL + 6) @(posedge ck);
    $display("test data done");
    #1 ctl.odt = 1'b1;
    ctl.cmd(CMD_MRS, 3'h4, 14'h0404);
    settle;
    check({term_on, s_diff, t_dq[13:0]}, 16'h4000);
    ctl.cmd(CMD_MRS, SEL_EMR1, 14'h0404);
    diff_exp = 1'b0;
    settle;
    check(t_dq, 16'hffff);
    check({8'h0, t_s, t_n, t_m, term_on, s_diff}, 16'hfe);
    rd(3'h2, 2'h3);
    // the done pulses need a few core cycles to cross; the masked read must add none
    settle;
    check({8'(n_wr), 8'(n_rd)}, 16'h0203);
    $display("test termination done");
    wrap_up;
  end
endmodule
